// [tpwm_map.vh]
// Register map, field positions, reset values for the PWM timing unit
// Assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef TPWM_MAP_VH
`define TPWM_MAP_VH
`define TPWM_OFS_HALF_PERIOD 8'h00
`define TPWM_OFS_DEAD_TIME 8'h04
`define TPWM_OFS_MIN_PULSE 8'h08
`define TPWM_OFS_SYNC_WIDTH 8'h0c
`define TPWM_OFS_DUTY_A 8'h10
`define TPWM_OFS_DUTY_B 8'h14
`define TPWM_OFS_DUTY_C 8'h18
`define TPWM_OFS_SEGMENT 8'h1c
`define TPWM_OFS_MODE 8'h20
`define TPWM_OFS_STATUS 8'h24
`define TPWM_MODE_DOUBLE_BIT 6
`define TPWM_STAT_HALF_BIT 3
`define TPWM_STAT_RUN_BIT 0
`define TPWM_SYNC_WIDTH_RST 8'h27
`define TPWM_SEG_RST 9'h000
`endif

// [tpwm_timing_unit.v]
// Three-phase center-based PWM timing unit with AHB-Lite register slave
// Assumes a single 100 MHz clock equal to the instruction clock, hresetn
// asynchronous active low, one AHB master with word transfers only
`timescale 1ns/1ps
`include "tpwm_map.vh"

// ****************************************************************
// Dead-time pair generator for one phase
// ****************************************************************
module tpwm_phase (
  input wire hclk,
  input wire hresetn,
  input wire run,
  input wire raw_hi,
  input wire [10:0] dead_ticks,
  output reg out_hi,
  output reg out_lo
);
  reg prev_r;
  reg [10:0] dcnt_r;

  // Edge-delay counter: restarts on every raw edge, so a demand
  // pulse shorter than the gap never reaches either gate
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= 1'b0;
      dcnt_r <= 11'h000;
      out_hi <= 1'b0;
      out_lo <= 1'b0;
    end else if (!run) begin
      prev_r <= 1'b0;
      dcnt_r <= 11'h000;
      out_hi <= 1'b0;
      out_lo <= 1'b0;
    end else begin
      prev_r <= raw_hi;
      if (raw_hi != prev_r) begin
        out_hi <= 1'b0;
        out_lo <= 1'b0;
        dcnt_r <= dead_ticks;
        // zero gap turns on at once
        if (dead_ticks == 11'h000) begin
          out_hi <= raw_hi;
          out_lo <= ~raw_hi;
        end
      end else if (dcnt_r > 11'h001) begin
        dcnt_r <= dcnt_r - 11'h001;
      end else begin
        dcnt_r <= 11'h000;
        out_hi <= raw_hi;
        out_lo <= ~raw_hi;
      end
    end
  end
endmodule // tpwm_phase

// ****************************************************************
// Duty comparator: raw high-side demand for one phase
// ****************************************************************
module tpwm_cmp #(
  parameter W = 16
) (
  input wire run,
  input wire [W-1:0] cnt,
  input wire [W-1:0] duty,
  input wire [W-1:0] half,
  output wire raw_hi
);
  wire [W:0] sum;

  // Widened sum so a long duty cannot wrap past zero
  assign sum = {1'b0, cnt} + {1'b0, duty};
  // Zero duty keeps the high side off for the whole period
  assign raw_hi = run && (sum >= {1'b0, half}) && (duty != {W{1'b0}});
endmodule // tpwm_cmp

// ****************************************************************
// Top: registers, period counter, sync pulse, three phases
// ****************************************************************
module tpwm_timing_unit (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire phase_a_high_out,
  output wire phase_a_low_out,
  output wire phase_b_high_out,
  output wire phase_b_low_out,
  output wire phase_c_high_out,
  output wire phase_c_low_out,
  output reg period_sync_pulse,
  output reg sync_irq,
  output reg [8:0] segment_active
);
  // Shadow registers written by software
  reg [15:0] half_period_count_r;
  reg [9:0] dead_time_count_r;
  reg [15:0] min_pulse_count_r;
  reg [7:0] sync_width_count_r;
  reg [15:0] duty_phase_a_r;
  reg [15:0] duty_phase_b_r;
  reg [15:0] duty_phase_c_r;
  reg [8:0] output_segment_control_r;
  reg [7:0] mode_control_r;
  reg [3:0] written_r;
  // Active copies
  reg [15:0] act_half_r;
  reg [9:0] act_dead_r;
  reg [15:0] act_minp_r;
  reg [7:0] act_sync_r;
  reg [15:0] act_da_r;
  reg [15:0] act_db_r;
  reg [15:0] act_dc_r;
  // Timing state
  reg run_r;
  reg down_r;
  reg second_half_r;
  reg [15:0] cnt_r;
  reg [8:0] sync_cnt_r;
  // Bus pipeline
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  wire addr_ok;
  wire [7:0] a8;
  wire latch;
  wire mid;
  wire start;
  wire dbl;
  wire [10:0] dead_ticks;
  wire [15:0] w16;
  wire sync_done;
  reg [31:0] status_word;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign a8 = haddr[7:0];
  assign addr_ok = hsel && htrans[1] && hready;
  assign w16 = hwdata[15:0];
  assign dbl = mode_control_r[`TPWM_MODE_DOUBLE_BIT];
  assign dead_ticks = {act_dead_r, 1'b0};
  // Pulse ends once the count reaches the latched width
  assign sync_done = (sync_cnt_r == {1'b0, act_sync_r});

  // Address phase capture for writes; the store lands at the end of
  // the data phase, so a read must not overlap a write's data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= a8;
    end
  end

  // Mode bit acts at once; timing values wait for a latch or mid edge
  // data-phase writes into shadows
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_period_count_r <= 16'h0000;
      dead_time_count_r <= 10'h000;
      min_pulse_count_r <= 16'h0000;
      sync_width_count_r <= `TPWM_SYNC_WIDTH_RST;
      duty_phase_a_r <= 16'h0000;
      duty_phase_b_r <= 16'h0000;
      duty_phase_c_r <= 16'h0000;
      output_segment_control_r <= `TPWM_SEG_RST;
      mode_control_r <= 8'h00;
      written_r <= 4'h0;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `TPWM_OFS_HALF_PERIOD: begin
          half_period_count_r <= w16;
          written_r[0] <= 1'b1;
        end
        `TPWM_OFS_DEAD_TIME: dead_time_count_r <= hwdata[9:0];
        `TPWM_OFS_MIN_PULSE: min_pulse_count_r <= w16;
        `TPWM_OFS_SYNC_WIDTH: sync_width_count_r <= hwdata[7:0];
        `TPWM_OFS_DUTY_A: begin
          duty_phase_a_r <= w16;
          written_r[1] <= 1'b1;
        end
        `TPWM_OFS_DUTY_B: begin
          duty_phase_b_r <= w16;
          written_r[2] <= 1'b1;
        end
        `TPWM_OFS_DUTY_C: begin
          duty_phase_c_r <= w16;
          written_r[3] <= 1'b1;
        end
        `TPWM_OFS_SEGMENT: output_segment_control_r <= hwdata[8:0];
        `TPWM_OFS_MODE: mode_control_r <= hwdata[7:0];
        default: written_r <= written_r;
      endcase
    end
  end

  // Status word assembled from its field positions
  always @* begin
    status_word = 32'h00000000;
    status_word[`TPWM_STAT_HALF_BIT] = second_half_r;
    status_word[`TPWM_STAT_RUN_BIT] = run_r;
  end

  // Read data registered in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (a8)
        `TPWM_OFS_HALF_PERIOD: hrdata <= {16'h0000, half_period_count_r};
        `TPWM_OFS_DEAD_TIME: hrdata <= {22'h000000, dead_time_count_r};
        `TPWM_OFS_MIN_PULSE: hrdata <= {16'h0000, min_pulse_count_r};
        `TPWM_OFS_SYNC_WIDTH: hrdata <= {24'h000000, sync_width_count_r};
        `TPWM_OFS_DUTY_A: hrdata <= {16'h0000, duty_phase_a_r};
        `TPWM_OFS_DUTY_B: hrdata <= {16'h0000, duty_phase_b_r};
        `TPWM_OFS_DUTY_C: hrdata <= {16'h0000, duty_phase_c_r};
        `TPWM_OFS_SEGMENT: hrdata <= {23'h000000, output_segment_control_r};
        `TPWM_OFS_MODE: hrdata <= {24'h000000, mode_control_r};
        `TPWM_OFS_STATUS: hrdata <= status_word;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  assign start = !run_r && (written_r == 4'hf);
  // Latch on the last down tick so a new period opens with fresh
  // active values and no idle cycle between periods
  // latch at period start
  assign latch = start || (run_r && down_r && cnt_r <= 16'h0001);
  assign mid = run_r && !down_r && (cnt_r + 16'h0001 >= act_half_r) && dbl;

  // Counter holds at zero until the first latch opens a period
  // up then down period counter, one tick per hclk
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
      down_r <= 1'b0;
      second_half_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (latch) begin
      run_r <= 1'b1;
      down_r <= 1'b0;
      second_half_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (run_r && !down_r) begin
      if (cnt_r + 16'h0001 >= act_half_r) begin
        down_r <= 1'b1;
        second_half_r <= 1'b1;
        // second half runs on the midpoint-latched length
        if (dbl) begin
          cnt_r <= half_period_count_r;
        end else begin
          cnt_r <= act_half_r;
        end
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end else if (run_r) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // shadow copy incl. segment on sync edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_half_r <= 16'h0000;
      act_dead_r <= 10'h000;
      act_minp_r <= 16'h0000;
      act_sync_r <= `TPWM_SYNC_WIDTH_RST;
      act_da_r <= 16'h0000;
      act_db_r <= 16'h0000;
      act_dc_r <= 16'h0000;
      segment_active <= `TPWM_SEG_RST;
    end else if (latch || mid) begin
      act_half_r <= half_period_count_r;
      act_dead_r <= dead_time_count_r;
      act_minp_r <= min_pulse_count_r;
      act_sync_r <= sync_width_count_r;
      act_da_r <= duty_phase_a_r;
      act_db_r <= duty_phase_b_r;
      act_dc_r <= duty_phase_c_r;
      segment_active <= output_segment_control_r;
    end
  end

  // sync high for width plus one ticks; rate via latch/mid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_cnt_r <= 9'h000;
      period_sync_pulse <= 1'b0;
      sync_irq <= 1'b0;
    end else begin
      sync_irq <= latch || mid;
      if (latch || mid) begin
        sync_cnt_r <= 9'h000;
        period_sync_pulse <= 1'b1;
      end else if (period_sync_pulse && !sync_done) begin
        sync_cnt_r <= sync_cnt_r + 9'h001;
      end else begin
        period_sync_pulse <= 1'b0;
      end
    end
  end

  // Center-based comparison: high when count at or above half minus duty
  wire raw_a;
  wire raw_b;
  wire raw_c;
  // one duty comparator per phase pair
  tpwm_cmp #(.W(16)) u_ca (.run(run_r), .cnt(cnt_r), .duty(act_da_r),
    .half(act_half_r), .raw_hi(raw_a));
  tpwm_cmp #(.W(16)) u_cb (.run(run_r), .cnt(cnt_r), .duty(act_db_r),
    .half(act_half_r), .raw_hi(raw_b));
  tpwm_cmp #(.W(16)) u_cc (.run(run_r), .cnt(cnt_r), .duty(act_dc_r),
    .half(act_half_r), .raw_hi(raw_c));

  tpwm_phase u_pa (.hclk(hclk), .hresetn(hresetn), .run(run_r),
    .raw_hi(raw_a), .dead_ticks(dead_ticks),
    .out_hi(phase_a_high_out), .out_lo(phase_a_low_out));
  tpwm_phase u_pb (.hclk(hclk), .hresetn(hresetn), .run(run_r),
    .raw_hi(raw_b), .dead_ticks(dead_ticks),
    .out_hi(phase_b_high_out), .out_lo(phase_b_low_out));
  tpwm_phase u_pc (.hclk(hclk), .hresetn(hresetn), .run(run_r),
    .raw_hi(raw_c), .dead_ticks(dead_ticks),
    .out_hi(phase_c_high_out), .out_lo(phase_c_low_out));
endmodule // tpwm_timing_unit

// [tpwm_chk.sv]
// Port checker for the PWM timing unit
// Assumes one clock hclk and async active-low hresetn
`timescale 1ns/1ps
module tpwm_chk (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire phase_a_high_out,
  input wire phase_a_low_out,
  input wire phase_b_high_out,
  input wire phase_b_low_out,
  input wire phase_c_high_out,
  input wire phase_c_low_out,
  input wire period_sync_pulse,
  input wire sync_irq,
  input wire [8:0] segment_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg [8:0] hi_cnt_r;
  // ****************************************
  // Sync pulse length counter
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hi_cnt_r <= 9'h000;
    else if (period_sync_pulse)
      hi_cnt_r <= hi_cnt_r + 9'h001;
    else
      hi_cnt_r <= 9'h000;
  end
  sequence sync_start;
    !period_sync_pulse ##1 period_sync_pulse;
  endsequence
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  pair_a_excl_a: assert property (!(phase_a_high_out && phase_a_low_out))
    else $error("phase a both on");
  pair_b_excl_a: assert property (!(phase_b_high_out && phase_b_low_out))
    else $error("phase b both on");
  pair_c_excl_a: assert property (!(phase_c_high_out && phase_c_low_out))
    else $error("phase c both on");
  irq_follows_sync_a: assert property (sync_start |-> sync_irq)
    else $error("no irq with sync start");
  irq_single_a: assert property (sync_irq |=> !sync_irq)
    else $error("irq longer than one cycle");
  irq_cause_a: assert property (sync_irq |-> period_sync_pulse
    && !$past(period_sync_pulse)) else $error("irq without sync start");
  sync_width_a: assert property (hi_cnt_r <= 9'h100)
    else $error("sync pulse over 256 ticks");
  seg_latch_a: assert property (!$stable(segment_active) |->
    period_sync_pulse || $past(period_sync_pulse)) else $error("segment moved");
endmodule // tpwm_chk

bind tpwm_timing_unit tpwm_chk chk_i (.hclk, .hresetn, .hreadyout, .hresp,
  .phase_a_high_out, .phase_a_low_out, .phase_b_high_out, .phase_b_low_out,
  .phase_c_high_out, .phase_c_low_out, .period_sync_pulse, .sync_irq,
  .segment_active);

// [tpwm_gate_model.sv]
// Gate-driver model for the six PWM outputs
// Assumes active-high gate commands sampled on hclk
`timescale 1ns/1ps
module tpwm_gate_model (
  input wire logic hclk,
  input wire logic [5:0] gate,
  output logic shoot
);
  initial shoot = 1'b0;
  // sticky flag on a shorted leg
  always @(posedge hclk) begin
    if ((gate[5] & gate[4]) | (gate[3] & gate[2]) | (gate[1] & gate[0])) begin
      shoot <= 1'b1;
    end
  end
endmodule // tpwm_gate_model

// [tb_top.sv]
// Self-checking bench for the PWM timing unit
// Assumes the register map header and a zero-wait AHB-Lite slave
`timescale 1ns/1ps
`include "tpwm_map.vh"
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  wire [31:0] hrdata;
  wire hreadyout, hresp, ah, al, bh, bl, ch, cl, sync, irq, shoot;
  wire [8:0] seg;
  int mismatches = 0;
  int comparisons = 0;
  int c, w;
  always #5 hclk = ~hclk;
  tpwm_timing_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phase_a_high_out(ah),
    .phase_a_low_out(al), .phase_b_high_out(bh), .phase_b_low_out(bl),
    .phase_c_high_out(ch), .phase_c_low_out(cl), .period_sync_pulse(sync),
    .sync_irq(irq), .segment_active(seg));
  tpwm_gate_model gm (.hclk(hclk), .gate({ah, al, bh, bl, ch, cl}),
    .shoot(shoot));
  // ****************************************
  // Shared tasks
  // ****************************************
  task conclude;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    mismatches++;
    $display("ERROR %0t: wait timed out", $time);
    conclude();
  endtask
  // One single AHB transfer, read data left in q
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) tmo();
  endtask
  // Wait for the next sync start, c counts cycles
  task wsync;
    logic p;
    logic hit;
    p = sync;
    c = 0;
    hit = 1'b0;
    while (!hit && c <= 3000) begin
      @(posedge hclk);
      c++;
      hit = (sync === 1'b1 && p === 1'b0);
      p = sync;
    end
    if (!hit) tmo();
  endtask
  // Sync width into w, start to start into c
  task wper;
    w = 1;
    @(posedge hclk);
    while (sync === 1'b1 && w < 300) begin
      w++;
      @(posedge hclk);
    end
    if (w >= 300) tmo();
    wsync();
    c = c + w;
  endtask
  // Cycles from a high-side fall to low-side rise into w
  task wgap;
    logic p;
    p = 1'b0;
    c = 0;
    while (!(p === 1'b1 && ah === 1'b0) && c < 3000) begin
      p = ah;
      @(posedge hclk);
      c++;
    end
    w = 0;
    while (al !== 1'b1 && w < 3000) begin
      @(posedge hclk);
      w++;
    end
    if (c >= 3000 || w >= 3000) tmo();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    bus(1'b0, `TPWM_OFS_SYNC_WIDTH, 32'h0);
    chk(q, 32'h27);
    bus(1'b0, `TPWM_OFS_MODE, 32'h0);
    chk(q & 32'h40, 32'h0);
    bus(1'b1, `TPWM_OFS_DEAD_TIME, 32'hffff);
    bus(1'b0, `TPWM_OFS_DEAD_TIME, 32'h0);
    chk(q, 32'h3ff);
    bus(1'b1, `TPWM_OFS_HALF_PERIOD, 32'h1ffff);
    bus(1'b0, `TPWM_OFS_HALF_PERIOD, 32'h0);
    chk(q, 32'hffff);
    bus(1'b1, 8'h40, 32'h5);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    $display("t_regs done");
  endtask
  task t_start;
    bus(1'b1, `TPWM_OFS_HALF_PERIOD, 32'd60);
    bus(1'b1, `TPWM_OFS_DEAD_TIME, 32'h0);
    bus(1'b1, `TPWM_OFS_DUTY_A, 32'd30);
    bus(1'b1, `TPWM_OFS_DUTY_B, 32'd20);
    c = 0;
    repeat (200) begin
      @(posedge hclk);
      if ((sync | ah | al | bh | bl | ch | cl) !== 1'b0) c++;
    end
    chk(c, 0);
    bus(1'b1, `TPWM_OFS_DUTY_C, 32'd10);
    wsync();
    wper();
    chk(w, 40);
    chk(c, 120);
    $display("t_start done");
  endtask
  task t_shadow;
    wsync();
    bus(1'b1, `TPWM_OFS_HALF_PERIOD, 32'd50);
    bus(1'b1, `TPWM_OFS_SYNC_WIDTH, 32'h3);
    bus(1'b1, `TPWM_OFS_SEGMENT, 32'h1ff);
    chk({23'h0, seg}, 32'h0);
    wsync();
    wper();
    chk({23'h0, seg}, 32'h1ff);
    chk(w, 4);
    chk(c, 100);
    wsync();
    bus(1'b0, `TPWM_OFS_STATUS, 32'h0);
    chk(q & 32'h8, 32'h0);
    repeat (50) @(posedge hclk);
    bus(1'b0, `TPWM_OFS_STATUS, 32'h0);
    chk(q & 32'h8, 32'h8);
    $display("t_shadow done");
  endtask
  task t_dead;
    wgap();
    chk(w, 0);
    bus(1'b1, `TPWM_OFS_DEAD_TIME, 32'h3);
    wsync();
    wgap();
    chk(w, 6);
    chk({31'h0, shoot}, 32'h0);
    $display("t_dead done");
  endtask
  task t_double;
    bus(1'b1, `TPWM_OFS_MODE, 32'h40);
    bus(1'b0, `TPWM_OFS_MODE, 32'h0);
    chk(q & 32'h40, 32'h40);
    wsync();
    // new duty and segment in the sync service
    bus(1'b1, `TPWM_OFS_DUTY_A, 32'd25);
    bus(1'b1, `TPWM_OFS_SEGMENT, 32'h0a5);
    chk({23'h0, seg}, 32'h1ff);
    wsync();
    chk({23'h0, seg}, 32'h0a5);
    wper();
    chk(c, 50);
    $display("t_double done");
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_start();
    t_shadow();
    t_dead();
    t_double();
    conclude();
  end
endmodule // tb_top
